/* inc/ext_irq_pkg.sv */
// package: register map, field layout, reset values and timing for the interrupt front-end
package ext_irq_pkg;

  // ************************************************
  // register offsets (i/o space)
  // ************************************************
  localparam logic [7:0] CPU_CONTROL_OFF = 8'h35;
  localparam logic [7:0] MASK_OFF = 8'h39;
  localparam logic [7:0] FLAGS_OFF = 8'h38;
  localparam logic [7:0] UPPER_SENSE_OFF = 8'h3a;
  localparam logic [7:0] LOWER_SENSE_OFF = 8'h6a;

  // ************************************************
  // field positions and reset values
  // ************************************************
  localparam int VEC_SEL_BIT = 1;
  localparam int VEC_CE_BIT = 0;
  localparam logic [7:0] SENSE_RESET = 8'h00;
  localparam logic [7:0] CPU_CONTROL_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // ************************************************
  // timing
  // ************************************************
  localparam logic [2:0] CHANGE_WINDOW_CYCLES = 3'h4;
  localparam int WAKE_SAMPLES = 2;

  // sense field encodings
  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_RSVD = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;

  // vector change sequence states
  typedef enum logic [1:0] {VC_IDLE, VC_OPEN, VC_TAIL} vc_state_e;

  // register access from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // fuse and lock configuration
  typedef struct packed {
    logic [15:0] boot_start;
    logic app_side_lock_bit;
    logic boot_side_lock_bit;
    logic compat_mode;
  } fuse_cfg_s;

endpackage

/* rtl/ext_irq_sense_and_vector_select.sv */
// external interrupt sense logic, pending flags and vector base selection
`timescale 1ns/1ns

module ext_irq_sense_and_vector_select (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register access
  input wire ext_irq_pkg::reg_req_s req_i,
  output logic [7:0] rdata_o,
  // core side
  input wire logic global_enable_i,
  input wire logic instr_done_i,
  input wire logic exec_in_boot_i,
  input wire logic [7:0] irq_ack_i,
  output logic [7:0] irq_req_o,
  output logic irq_block_o,
  output logic [15:0] vector_base_o,
  // fuses and power state
  input wire ext_irq_pkg::fuse_cfg_s fuse_i,
  input wire logic sleep_i,
  input wire logic idle_mode_i,
  input wire logic power_down_i,
  input wire logic wdt_tick_i,
  input wire logic startup_done_i,
  output logic wake_o,
  // pins
  input wire logic [7:0] ext_request_pins_i
);
  import ext_irq_pkg::*;

  // ************************************************
  // declarations
  // ************************************************
  logic [7:0] lower_sense_control_q;
  logic [7:0] upper_sense_control_q;
  logic [7:0] ext_irq_mask_q;
  logic [7:0] ext_irq_flags_q;
  logic [7:0] ext_irq_flags_d;
  logic vector_base_select_q;
  logic vector_change_enable_q;
  logic [2:0] ce_count_q;
  vc_state_e vc_state_q;
  vc_state_e vc_state_d;
  logic [7:0] pin_sync;
  logic [7:0] pin_prev_q;
  logic [7:0] req_next;
  logic [15:0] vector_base_d;
  logic wake_direct;
  logic [7:0] pin_view;
  logic [7:0] rise;
  logic [7:0] fall;
  logic [7:0] is_level;
  logic [7:0] trig;
  logic [7:0] flag_w1c;
  logic [15:0] sense_all;
  logic wr_cpu;
  logic wr_mask;
  logic wr_flags;
  logic wr_upper;
  logic wr_lower;
  logic sel_write;
  logic ce_write;
  logic clock_running;
  logic lock_block;
  logic seq_block;
  logic [7:0] enabled;
  logic [7:0] rdata_d;
  logic wake_level;
  logic wake_ok;
  logic pd_low;

  // sense decode for one input
  function automatic logic [1:0] sense_of(input logic [15:0] all, input int idx);
    sense_of = all[2*idx +: 2];
  endfunction

  // ************************************************
  // address decode
  // ************************************************
  // lower register hidden
  assign wr_lower = req_i.wr && (req_i.addr == LOWER_SENSE_OFF) && !fuse_i.compat_mode;
  assign wr_upper = req_i.wr && (req_i.addr == UPPER_SENSE_OFF);
  assign wr_cpu = req_i.wr && (req_i.addr == CPU_CONTROL_OFF);
  assign wr_mask = req_i.wr && (req_i.addr == MASK_OFF);
  assign wr_flags = req_i.wr && (req_i.addr == FLAGS_OFF);
  assign sel_write = wr_cpu && vector_change_enable_q && !req_i.wdata[VEC_CE_BIT];
  assign ce_write = wr_cpu && req_i.wdata[VEC_CE_BIT];

  // read mux
  always_comb begin
    if (req_i.addr == CPU_CONTROL_OFF) begin
      rdata_d = {6'h00, vector_base_select_q, vector_change_enable_q};
    end else if (req_i.addr == MASK_OFF) begin
      rdata_d = ext_irq_mask_q;
    end else if (req_i.addr == FLAGS_OFF) begin
      rdata_d = ext_irq_flags_q;
    end else if (req_i.addr == UPPER_SENSE_OFF) begin
      rdata_d = upper_sense_control_q;
    end else if (req_i.addr == LOWER_SENSE_OFF && !fuse_i.compat_mode) begin
      rdata_d = lower_sense_control_q;
    end else begin
      rdata_d = 8'h00;
    end
  end

  // ************************************************
  // registers
  // ************************************************
  // lower sense storage
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lower_sense_control_q <= SENSE_RESET;
    end else if (wr_lower) begin
      lower_sense_control_q <= req_i.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      upper_sense_control_q <= SENSE_RESET;
    end else if (wr_upper) begin
      upper_sense_control_q <= req_i.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ext_irq_mask_q <= MASK_RESET;
    end else if (wr_mask) begin
      ext_irq_mask_q <= req_i.wdata;
    end
  end

  // read data, held until the next read
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (req_i.rd) begin
      rdata_o <= rdata_d;
    end
  end

  // ************************************************
  // vector change sequence
  // ************************************************
  // sequence state
  always_comb begin
    vc_state_d = vc_state_q;
    case (vc_state_q)
      VC_IDLE: begin
        if (ce_write) begin
          vc_state_d = VC_OPEN;
        end
      end
      VC_OPEN: begin
        if (sel_write) begin
          vc_state_d = VC_TAIL;
        end else if (ce_count_q == CHANGE_WINDOW_CYCLES - 3'h1) begin
          vc_state_d = VC_IDLE;
        end
      end
      VC_TAIL: begin
        if (instr_done_i) begin
          vc_state_d = VC_IDLE;
        end
      end
      default: vc_state_d = VC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      vc_state_q <= VC_IDLE;
      vector_base_select_q <= CPU_CONTROL_RESET[VEC_SEL_BIT];
      vector_change_enable_q <= CPU_CONTROL_RESET[VEC_CE_BIT];
      ce_count_q <= 3'h0;
    end else begin
      vc_state_q <= vc_state_d;
      if (sel_write) begin
        vector_base_select_q <= req_i.wdata[VEC_SEL_BIT];
      end
      vector_change_enable_q <= (vc_state_d == VC_OPEN);
      ce_count_q <= (vc_state_q == VC_OPEN) ? ce_count_q + 3'h1 : 3'h0;
    end
  end

  assign seq_block = (vc_state_q != VC_IDLE) || ce_write;
  assign lock_block = (vector_base_select_q && !exec_in_boot_i && fuse_i.app_side_lock_bit) ||
                      (!vector_base_select_q && exec_in_boot_i && fuse_i.boot_side_lock_bit);

  // ************************************************
  // pin sampling and edge detection
  // ************************************************
  // sample pins regardless of direction
  pin_sync3 #(.WIDTH(8)) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(ext_request_pins_i),
    .level_o(pin_sync)
  );

  // clock gated off in deep sleep
  assign clock_running = !sleep_i || idle_mode_i;
  assign pin_view = pin_sync;
  assign rise = pin_view & ~pin_prev_q;
  assign fall = ~pin_view & pin_prev_q;
  assign sense_all = {upper_sense_control_q, lower_sense_control_q};

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      is_level[i] = (sense_of(sense_all, i) == SENSE_LOW);
      case (sense_of(sense_all, i))
        SENSE_LOW: trig[i] = !pin_view[i];
        SENSE_FALL: trig[i] = fall[i] && (i < 4 || clock_running);
        SENSE_RISE: trig[i] = rise[i] && (i < 4 || clock_running);
        default: trig[i] = 1'b0;
      endcase
    end
  end

  // previous sample taken every cycle, no sleep gating
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin_prev_q <= 8'hff;
    end else begin
      pin_prev_q <= pin_view;
    end
  end

  // ************************************************
  // pending flags and requests
  // ************************************************
  assign flag_w1c = (wr_flags ? req_i.wdata : 8'h00) | irq_ack_i;
  // set wins over clear, level keeps clear
  assign ext_irq_flags_d = ((ext_irq_flags_q & ~flag_w1c) | (trig & ~is_level)) & ~is_level;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ext_irq_flags_q <= FLAGS_RESET;
    end else begin
      ext_irq_flags_q <= ext_irq_flags_d;
    end
  end

  // power-down wake on any enabled low level
  assign wake_level = |(ext_irq_mask_q & is_level & ~pin_view);
  wake_sampler u_wake (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .power_down_i(power_down_i),
    .wdt_tick_i(wdt_tick_i),
    .startup_done_i(startup_done_i),
    .level_low_i(wake_level),
    .wake_o(pd_low),
    .irq_ok_o(wake_ok)
  );

  // gating; level requests follow the pin
  assign enabled = ext_irq_mask_q & {8{global_enable_i && !seq_block && !lock_block}} &
                   {8{!power_down_i || wake_ok}};

  // level requests follow the pin, edge requests follow the flag
  assign req_next = enabled & ((ext_irq_flags_d & ~is_level) | (is_level & trig));
  // base from the boot start fuse when the vector base select bit is set, else zero
  assign vector_base_d = vector_base_select_q ? fuse_i.boot_start : 16'h0000;
  // lower edges, upper edges in idle and levels wake a sleeping part
  // in power-down a level must first pass the slow double sample
  assign wake_direct = |(ext_irq_mask_q & trig & ~(is_level & {8{power_down_i}}));

  // ************************************************
  // registered outputs
  // ************************************************
  // requests toward the core
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_req_o <= 8'h00;
    end else begin
      irq_req_o <= req_next;
    end
  end

  // blocking status, global enable left alone
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_block_o <= 1'b0;
    end else begin
      irq_block_o <= seq_block || lock_block;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      vector_base_o <= 16'h0000;
    end else begin
      vector_base_o <= vector_base_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= sleep_i && (pd_low || wake_direct);
    end
  end
endmodule // ext_irq_sense_and_vector_select

/* rtl/pin_sync3.sv */
// three-stage pin synchroniser, change accepted when stages two and three agree
`timescale 1ns/1ns
module pin_sync3 #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // pins
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] agree;

  // accept only settled values; idle level is high for active-low pins
  assign agree = (s2_q & s3_q) | (level_o & (s2_q | s3_q));

  // sampling chain
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      level_o <= '1;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_o <= agree;
    end
  end
endmodule // pin_sync3

/* rtl/wake_sampler.sv */
// power-down wake qualifier: low level sampled twice on watchdog-oscillator ticks
`timescale 1ns/1ns
module wake_sampler (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic power_down_i,
  input wire logic wdt_tick_i,
  input wire logic startup_done_i,
  input wire logic level_low_i,
  // results
  output logic wake_o,
  output logic irq_ok_o
);
  import ext_irq_pkg::*;
  logic [1:0] hits_q;
  logic [1:0] hits_d;
  logic held_q;

  // consecutive low samples on the slow tick
  assign hits_d = !level_low_i ? 2'h0 :
                  (hits_q == 2'(WAKE_SAMPLES)) ? hits_q : hits_q + 2'h1;

  // wake latch, then irq only if the level survives start-up
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !power_down_i) begin
      hits_q <= 2'h0;
      wake_o <= 1'b0;
      held_q <= 1'b0;
      irq_ok_o <= 1'b0;
    end else begin
      if (wdt_tick_i) begin
        hits_q <= hits_d;
      end
      if (hits_q == 2'(WAKE_SAMPLES)) begin
        wake_o <= 1'b1;
      end
      held_q <= wake_o ? (held_q & level_low_i) | (!held_q & level_low_i & !irq_ok_o) : 1'b1;
      irq_ok_o <= wake_o & startup_done_i & level_low_i & held_q;
    end
  end
endmodule // wake_sampler

/* test/ext_irq_asserts.sv */
// checker: port relations of the interrupt front-end
`timescale 1ns/1ns
module ext_irq_asserts
  import ext_irq_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // watched ports
  input wire ext_irq_pkg::reg_req_s req_i,
  input wire logic [7:0] rdata_o,
  input wire logic global_enable_i,
  input wire logic [7:0] irq_req_o,
  input wire logic irq_block_o,
  input wire logic [15:0] vector_base_o,
  input wire ext_irq_pkg::fuse_cfg_s fuse_i,
  input wire logic power_down_i,
  input wire logic sleep_i,
  input wire logic wake_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ************
  // sequences
  // ************
  wire lock_free = !fuse_i.app_side_lock_bit && !fuse_i.boot_side_lock_bit;
  sequence ce_wr;
    req_i.wr && req_i.addr == CPU_CONTROL_OFF && req_i.wdata[VEC_CE_BIT];
  endsequence
  sequence up_wr_rd;
    req_i.wr && req_i.addr == UPPER_SENSE_OFF ##1 req_i.rd && req_i.addr == UPPER_SENSE_OFF;
  endsequence
  // ************
  // assertions
  // ************
  base_pick_a: assert property (
    vector_base_o == 16'h0000 || vector_base_o == fuse_i.boot_start)
    else $error("vector base is neither start");
  ce_block_a: assert property (ce_wr |=> irq_block_o)
    else $error("no blocking after change enable");
  ce_expire_a: assert property (
    ce_wr ##1 (!req_i.wr && lock_free) [*6] |-> !irq_block_o)
    else $error("blocking outlived the change window");
  base_move_a: assert property ($changed(vector_base_o) |-> $past(irq_block_o, 2))
    else $error("vector base moved outside a change sequence");
  en_gate_a: assert property ((!global_enable_i) [*3] |-> irq_req_o == 8'h00)
    else $error("request with global enable low");
  compat_hide_a: assert property (
    req_i.rd && req_i.addr == LOWER_SENSE_OFF && fuse_i.compat_mode |=> rdata_o == 8'h00)
    else $error("hidden register readable");
  rd_back_a: assert property (up_wr_rd |=> rdata_o == $past(req_i.wdata, 2))
    else $error("sense readback differs");
  wake_pd_a: assert property ($rose(wake_o) |-> $past(sleep_i))
    else $error("wake while awake");
  pd_gate_a: assert property (power_down_i ##1 (irq_req_o != 8'h00) |-> $past(wake_o))
    else $error("request in power-down without wake");
endmodule // ext_irq_asserts

bind ext_irq_sense_and_vector_select ext_irq_asserts chk (.clk_i, .rst_n_i, .req_i,
  .rdata_o, .global_enable_i, .irq_req_o, .irq_block_o, .vector_base_o, .fuse_i,
  .power_down_i, .sleep_i, .wake_o);

/* test/ext_pin_source.sv */
// model of the signal sources on the request pins
`timescale 1ns/1ns
module ext_pin_source (
  // clock
  input wire logic clk_i,
  // level wanted by the bench and source speed
  input wire logic [7:0] level_i,
  input wire logic slow_i,
  // pins
  output logic [7:0] pins_o
);
  logic [7:0] d1_q = 8'hff;
  logic [7:0] d2_q = 8'hff;
  // a slow source lags the wanted level by two cycles
  always @(posedge clk_i) begin
    d1_q <= level_i;
    d2_q <= d1_q;
  end
  assign pins_o = slow_i ? d2_q : level_i;
endmodule // ext_pin_source

/* test/tb.sv */
// testbench: registers, sense modes, vector move and wake of the interrupt front-end
`timescale 1ns/1ns
module tb;
  import ext_irq_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  reg_req_s req = '0;
  logic [7:0] rdata, irq_req, pins, ack = '0, lvl = 8'hff;
  logic ge = 1'b0, done = 1'b0, slp = 1'b0, pd = 1'b0, tick = 1'b0, sup = 1'b0;
  logic blk, wake, slow = 1'b0, w, boot = 1'b0, idle = 1'b0;
  logic [15:0] base;
  fuse_cfg_s fuse = '{16'hf000, 1'b0, 1'b0, 1'b0};
  int failures = 0, n_checks = 0;
  logic [7:0] m [int]; // modelled register contents
  logic [7:0] offs [6] = '{CPU_CONTROL_OFF, FLAGS_OFF, MASK_OFF, UPPER_SENSE_OFF,
    LOWER_SENSE_OFF, 8'h40};
  // clock
  initial forever #4 clk_i = ~clk_i;
  ext_irq_sense_and_vector_select DUT (.clk_i, .rst_n_i, .req_i(req), .rdata_o(rdata),
    .global_enable_i(ge), .instr_done_i(done), .exec_in_boot_i(boot), .irq_ack_i(ack),
    .irq_req_o(irq_req), .irq_block_o(blk), .vector_base_o(base), .fuse_i(fuse),
    .sleep_i(slp), .idle_mode_i(idle), .power_down_i(pd), .wdt_tick_i(tick),
    .startup_done_i(sup), .wake_o(wake), .ext_request_pins_i(pins));
  ext_pin_source src (.clk_i, .level_i(lvl), .slow_i(slow), .pins_o(pins));
  // ************
  // tasks
  // ************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic acc(input logic wr_en, rd_en, input logic [7:0] a, d);
    req = '{wr_en, rd_en, a, d};
    @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, d);
    acc(1'b1, 1'b0, a, d);
    if (a != FLAGS_OFF && a != CPU_CONTROL_OFF && !(fuse.compat_mode && a == LOWER_SENSE_OFF))
      m[a] = d;
  endtask
  task automatic rd(input logic [7:0] a);
    acc(1'b0, 1'b1, a, 8'h00);
    chk(rdata, m.exists(a) ? m[a] : 8'h00, "read");
  endtask
  task automatic cyc(input int n);
    req = '0;
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wreq(input logic [7:0] exp);
    req = '0;
    for (int i = 0; i < 30 && irq_req !== exp; i++) begin
      @(posedge clk_i);
      #1;
    end
    chk(irq_req, exp, "request");
  endtask
  task automatic do_reset();
    rst_n_i = 1'b0;
    m.delete();
    cyc(20);
    rst_n_i = 1'b1;
  endtask
  task automatic arm(input logic [7:0] up, lo, msk);
    wr(MASK_OFF, 8'h00);
    wr(UPPER_SENSE_OFF, up);
    wr(LOWER_SENSE_OFF, lo);
    cyc(10);
    wr(FLAGS_OFF, 8'hff);
    wr(MASK_OFF, msk);
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ************
  // tests
  // ************
  initial begin
    void'($urandom(32'h824e5a47));
    do_reset();
    foreach (offs[i]) rd(offs[i]);
    for (int i = 0; i < 2; i++) begin
      wr(UPPER_SENSE_OFF, i ? 8'($urandom) : 8'h55);
      rd(UPPER_SENSE_OFF);
      wr(LOWER_SENSE_OFF, 8'($urandom));
      rd(LOWER_SENSE_OFF);
      wr(MASK_OFF, 8'($urandom));
      rd(MASK_OFF);
    end
    wr(CPU_CONTROL_OFF, 8'h02);
    cyc(3);
    chk(base, 16'h0000, "select without enable");
    wr(CPU_CONTROL_OFF, 8'h01);
    wr(CPU_CONTROL_OFF, 8'h02);
    done = 1'b1;
    cyc(1);
    done = 1'b0;
    cyc(2);
    chk(base, fuse.boot_start, "vector base");
    m[CPU_CONTROL_OFF] = 8'h02;
    rd(CPU_CONTROL_OFF);
    chk(blk, 1'b0, "block after move");
    wr(CPU_CONTROL_OFF, 8'h01);
    cyc(8);
    chk(blk, 1'b0, "block expiry");
    rd(CPU_CONTROL_OFF);
    fuse.app_side_lock_bit = 1'b1;
    cyc(2);
    chk(blk, 1'b1, "app side lock");
    boot = 1'b1;
    cyc(2);
    chk(blk, 1'b0, "lock released in boot");
    {boot, fuse.app_side_lock_bit} = 2'b00;
    ge = 1'b1;
    for (int k = 0; k < 2; k++) begin
      arm(k ? 8'hff : 8'haa, k ? 8'hff : 8'haa, 8'hff);
      slow = k[0];
      lvl = k ? 8'hff : 8'h00;
      wreq(8'hff);
      m[FLAGS_OFF] = 8'hff;
      rd(FLAGS_OFF);
      if (k) begin
        ack = 8'hff;
        cyc(1);
        ack = 8'h00;
      end else wr(FLAGS_OFF, 8'hff);
      wreq(8'h00);
    end
    arm(8'h00, 8'h00, 8'hff);
    lvl = 8'h5a;
    wreq(8'ha5);
    m[FLAGS_OFF] = 8'h00;
    rd(FLAGS_OFF);
    ge = 1'b0;
    wreq(8'h00);
    ge = 1'b1;
    wr(MASK_OFF, 8'h0f);
    wreq(8'h05);
    lvl = 8'hff;
    arm(8'haa, 8'h00, 8'hf0);
    slp = 1'b1;
    lvl = 8'h0f;
    cyc(12);
    chk(irq_req, 8'h00, "sleeping edge");
    idle = 1'b1;
    lvl = 8'hff;
    cyc(8);
    lvl = 8'h0f;
    wreq(8'hf0);
    idle = 1'b0;
    slp = 1'b0;
    lvl = 8'hff;
    arm(8'h00, 8'h00, 8'h01);
    slp = 1'b1;
    pd = 1'b1;
    lvl = 8'hfe;
    w = 1'b0;
    for (int i = 0; i < 40; i++) begin
      tick = (i % 4 == 0);
      w = w | wake;
      @(posedge clk_i);
      #1;
    end
    tick = 1'b0;
    chk(w, 1'b1, "wake");
    sup = 1'b1;
    wreq(8'h01);
    {pd, slp, sup} = 3'b000;
    lvl = 8'hff;
    fuse.compat_mode = 1'b1;
    do_reset();
    chk(base, 16'h0000, "base after reset");
    fuse.boot_side_lock_bit = 1'b1;
    boot = 1'b1;
    cyc(2);
    chk(blk, 1'b1, "boot side lock");
    {boot, fuse.boot_side_lock_bit} = 2'b00;
    wr(LOWER_SENSE_OFF, 8'hff);
    rd(LOWER_SENSE_OFF);
    complete_run();
  end
  // watchdog
  initial begin
    #200000;
    failures++;
    complete_run();
  end
endmodule // tb
